// ### hw/dcs_pkg.sv
package dcs_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [3:0] DCS_ADDR_CONFIG = 4'h0;
	localparam logic [3:0] DCS_ADDR_STATUS = 4'h4;
	localparam logic [31:0] DCS_CONFIG_RESET = 32'h00000000;
	localparam int DCS_GAP_W = 4;
	// field positions (low bit of each 4-bit field)
	localparam int DCS_POS_RMW = 28;
	localparam int DCS_POS_R2W = 24;
	localparam int DCS_POS_W2W_CS = 20;
	localparam int DCS_POS_W2W = 16;
	localparam int DCS_POS_R2R_CS = 12;
	localparam int DCS_POS_R2R = 8;
	localparam int DCS_POS_W2R_CS = 4;
	localparam int DCS_POS_W2R = 0;

	// ----------------------------------------------------------------
	// command carrier
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DCS_CMD_READ = 2'b00,
		DCS_CMD_WRITE = 2'b01,
		DCS_CMD_RMW_WRITE = 2'b10
	} dcs_kind_type;

	typedef struct packed {
		dcs_kind_type kind;
		logic [1:0] cs;
	} dcs_cmd_type;
endpackage

// ### hw/dcs_gap_counter.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// one spacing counter: loads a gap on an issue, counts down
// ----------------------------------------------------------------
module dcs_gap_counter #(
	parameter int W = 4
) (
	input wire logic clock_in, // controller clock
	input wire logic rst_in, // sync reset, active high
	input wire logic load_in, // earlier command issued this cycle
	input wire logic [W-1:0] gap_in, // programmed gap in clocks
	output logic [W-1:0] left_out // clocks still to wait
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	// a gap of n means the next command may issue n cycles after this one
	assign cnt_nxt = load_in ? gap_in : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
	assign left_out = cnt_r;
endmodule

// ### hw/dcs_spacing_timer.sv
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
module dcs_spacing_timer
	import dcs_pkg::*;
(
	input wire logic clock_in, // controller clock
	input wire logic rst_in, // sync reset, active high
	input wire logic [3:0] avs_address, // byte address
	input wire logic avs_read, // read strobe
	input wire logic avs_write, // write strobe
	input wire logic [3:0] avs_byteenable, // write lanes
	input wire logic [31:0] avs_writedata, // write data
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic cmd_valid_in, // scheduler offers a command
	input wire dcs_pkg::dcs_cmd_type cmd_in, // kind and chip select
	output logic cmd_issue_out, // command goes to memory this cycle
	output dcs_pkg::dcs_cmd_type cmd_out, // issued command
	output logic busy_out // offered command held back
);
	import dcs_pkg::*;

	// ----------------------------------------------------------------
	// register slave
	// ----------------------------------------------------------------
	logic [31:0] config_r;
	logic [31:0] config_nxt;
	logic wait_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [31:0] bemask;
	wire req = avs_read | avs_write;
	wire hit_cfg = (avs_address == DCS_ADDR_CONFIG);
	wire hit_sts = (avs_address == DCS_ADDR_STATUS);
	wire ack = ~wait_r; // answer cycle of a request
	// a write lands only on the edge that ends the answer cycle
	wire do_wr = avs_write & ack & hit_cfg;

	assign bemask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign config_nxt = do_wr ? ((config_r & ~bemask) | (avs_writedata & bemask)) : config_r;

	// ----------------------------------------------------------------
	// spacing counters
	// ----------------------------------------------------------------
	logic [DCS_GAP_W-1:0] gap [8];
	logic [DCS_GAP_W-1:0] left [8];
	logic [7:0] load;
	logic block;
	logic [1:0] last_rd_cs_r;
	logic [1:0] last_wr_cs_r;
	logic rd_seen_r;
	logic wr_seen_r;

	assign gap[0] = config_r[DCS_POS_RMW +: DCS_GAP_W];
	assign gap[1] = config_r[DCS_POS_R2W +: DCS_GAP_W];
	assign gap[2] = config_r[DCS_POS_W2W_CS +: DCS_GAP_W];
	assign gap[3] = config_r[DCS_POS_W2W +: DCS_GAP_W];
	assign gap[4] = config_r[DCS_POS_R2R_CS +: DCS_GAP_W];
	assign gap[5] = config_r[DCS_POS_R2R +: DCS_GAP_W];
	assign gap[6] = config_r[DCS_POS_W2R_CS +: DCS_GAP_W];
	assign gap[7] = config_r[DCS_POS_W2R +: DCS_GAP_W];

	wire issue = cmd_valid_in & ~block;
	wire is_rd = (cmd_in.kind == DCS_CMD_READ);
	wire is_wr = ~is_rd;
	// counters 0,1 start on reads, 2-7 index by earlier kind
	wire [7:0] load_sel = {is_wr, is_wr, is_rd, is_rd, is_wr, is_wr, is_rd, is_rd};
	// each counter starts only on an issue of its earlier kind
	assign load = {8{issue}} & load_sel;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : gen_gap
			dcs_gap_counter #(.W(DCS_GAP_W)) u_cnt (
				.clock_in(clock_in),
				.rst_in(rst_in),
				.load_in(load[g]),
				.gap_in(gap[g]),
				.left_out(left[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// hold decision: any applicable counter above one blocks
	// ----------------------------------------------------------------
	wire same_rd = (cmd_in.cs == last_rd_cs_r);
	wire same_wr = (cmd_in.cs == last_wr_cs_r);
	wire blk_rmw = (cmd_in.kind == DCS_CMD_RMW_WRITE) && (left[0] > 1);
	wire blk_r2w = is_wr && rd_seen_r && (left[1] > 1);
	wire blk_w2wc = is_wr && wr_seen_r && !same_wr && (left[2] > 1);
	wire blk_w2w = is_wr && wr_seen_r && same_wr && (left[3] > 1);
	wire blk_r2rc = is_rd && rd_seen_r && !same_rd && (left[4] > 1);
	wire blk_r2r = is_rd && rd_seen_r && same_rd && (left[5] > 1);
	wire blk_w2rc = is_rd && wr_seen_r && !same_wr && (left[6] > 1);
	wire blk_w2r = is_rd && wr_seen_r && same_wr && (left[7] > 1);
	// or of all holds equals waiting out the largest remaining gap
	assign block = blk_rmw | blk_r2w | blk_w2wc | blk_w2w
		| blk_r2rc | blk_r2r | blk_w2rc | blk_w2r;

	assign rdata_nxt = hit_cfg ? config_r : (hit_sts ? {30'h00000000, busy_out, cmd_issue_out}
		: 32'h00000000);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			config_r <= DCS_CONFIG_RESET;
			wait_r <= 1'b1;
			rdata_r <= 32'h00000000;
		end else begin
			config_r <= config_nxt;
			wait_r <= ~(req & wait_r);
			rdata_r <= rdata_nxt;
		end
	end

	// command history; outputs straight from flops
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			last_rd_cs_r <= 2'h0;
			last_wr_cs_r <= 2'h0;
			rd_seen_r <= 1'b0;
			wr_seen_r <= 1'b0;
			cmd_issue_out <= 1'b0;
			cmd_out <= '0;
			busy_out <= 1'b0;
		end else begin
			if (issue && is_rd) begin
				last_rd_cs_r <= cmd_in.cs;
				rd_seen_r <= 1'b1;
			end
			if (issue && is_wr) begin
				last_wr_cs_r <= cmd_in.cs;
				wr_seen_r <= 1'b1;
			end
			cmd_issue_out <= issue;
			cmd_out <= cmd_in;
			busy_out <= cmd_valid_in & block;
		end
	end

	// waitrequest straight from a flop: high while idle, so every request
	// sees one wait cycle and then one answer cycle
	assign avs_waitrequest = wait_r;
	assign avs_readdata = rdata_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// own distance counters, kept apart from the gap counters so that a
	// wrong load select or hold compare in the timer trips the checks below
	logic [DCS_GAP_W:0] since_rd_r;
	logic [DCS_GAP_W:0] since_wr_r;
	logic [DCS_GAP_W-1:0] rmw_at_rd_r;
	logic [DCS_GAP_W-1:0] r2w_at_rd_r;
	logic [DCS_GAP_W-1:0] w2r_at_wr_r;
	logic [1:0] cs_at_wr_r;
	wire rd_went = issue & is_rd;
	wire wr_went = issue & is_wr;
	wire [DCS_GAP_W:0] since_one = {{DCS_GAP_W{1'b0}}, 1'b1};
	// distances saturate, so a long quiet spell reads as far apart
	wire [DCS_GAP_W:0] since_rd_nxt = rd_went ? since_one
		: ((since_rd_r == '1) ? since_rd_r : since_rd_r + 1'b1);
	wire [DCS_GAP_W:0] since_wr_nxt = wr_went ? since_one
		: ((since_wr_r == '1) ? since_wr_r : since_wr_r + 1'b1);

	// gaps are captured at the earlier issue, as the counters load them
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			since_rd_r <= '1;
			since_wr_r <= '1;
			rmw_at_rd_r <= '0;
			r2w_at_rd_r <= '0;
			w2r_at_wr_r <= '0;
			cs_at_wr_r <= 2'h0;
		end else begin
			since_rd_r <= since_rd_nxt;
			since_wr_r <= since_wr_nxt;
			if (rd_went) begin
				rmw_at_rd_r <= gap[0];
				r2w_at_rd_r <= gap[1];
			end
			if (wr_went) begin
				w2r_at_wr_r <= gap[7];
				cs_at_wr_r <= cmd_in.cs;
			end
		end
	end

	a_rmw_gap_held: assert property (@(posedge clock_in) disable iff (rst_in)
		(issue && cmd_in.kind == DCS_CMD_RMW_WRITE) |-> (since_rd_r >= {1'b0, rmw_at_rd_r}))
		else $error("rmw write too soon");
	a_r2w_distance: assert property (@(posedge clock_in) disable iff (rst_in)
		wr_went |-> (since_rd_r >= {1'b0, r2w_at_rd_r}))
		else $error("write too soon after read");
	a_w2r_distance: assert property (@(posedge clock_in) disable iff (rst_in)
		(rd_went && cmd_in.cs == cs_at_wr_r) |-> (since_wr_r >= {1'b0, w2r_at_wr_r}))
		else $error("same select read too soon after write");
	a_r2w_gap_held: assert property (@(posedge clock_in) disable iff (rst_in)
		(issue && is_rd && gap[1] > 4'h1) |=> (left[1] == $past(gap[1])))
		else $error("read to write counter not loaded");
	a_w2w_cross: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_seen_r && is_wr && !same_wr && left[2] > 4'h1) |-> !issue)
		else $error("cross select write too soon");
	a_w2w_same: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_seen_r && is_wr && same_wr && left[3] > 4'h1) |-> !issue)
		else $error("same select write too soon");
	a_r2r_cross: assert property (@(posedge clock_in) disable iff (rst_in)
		(rd_seen_r && is_rd && !same_rd && left[4] > 4'h1) |-> !issue)
		else $error("cross select read too soon");
	a_r2r_same: assert property (@(posedge clock_in) disable iff (rst_in)
		(rd_seen_r && is_rd && same_rd && left[5] > 4'h1) |-> !issue)
		else $error("same select read too soon");
	a_w2r_cross: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_seen_r && is_rd && !same_wr && left[6] > 4'h1) |-> !issue)
		else $error("cross select read after write too soon");
	a_w2r_same: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_seen_r && is_rd && same_wr && left[7] > 4'h1) |-> !issue)
		else $error("same select read after write too soon");
	a_counts_down: assert property (@(posedge clock_in) disable iff (rst_in)
		(!issue && left[5] != 4'h0) |=> (left[5] == $past(left[5]) - 4'h1))
		else $error("spacing counter stalled");
	a_bus_one_wait: assert property (@(posedge clock_in) disable iff (rst_in)
		($rose(req)) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer late");

	c_back_reads: cover property (@(posedge clock_in) disable iff (rst_in)
		issue && is_rd ##1 issue && is_rd);
	c_write_held: cover property (@(posedge clock_in) disable iff (rst_in) blk_w2w);
	c_rmw_pair: cover property (@(posedge clock_in) disable iff (rst_in)
		issue && is_rd ##[1:16] issue && cmd_in.kind == DCS_CMD_RMW_WRITE);
	c_cfg_write: cover property (@(posedge clock_in) disable iff (rst_in) do_wr);
endmodule

// ### verif/dcs_mem_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// far-side memory: stamps the cycle of every command it receives
// ----------------------------------------------------------------
module dcs_mem_model
	import dcs_pkg::*;
(
	input wire logic clock_in, // controller clock
	input wire logic rst_in, // sync reset, active high
	input wire logic cmd_issue_in, // command arrives this cycle
	input wire dcs_pkg::dcs_cmd_type cmd_in, // kind and select
	output int count_out, // commands received
	output int stamp0_out, // cycle of the third newest command
	output int stamp1_out, // cycle of the second newest command
	output int stamp2_out, // cycle of the newest command
	output dcs_pkg::dcs_cmd_type last_out // newest command
);
	int cyc_r;

	// stamps are relative, so only differences between them matter
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			cyc_r <= 0;
			count_out <= 0;
		end else begin
			cyc_r <= cyc_r + 1;
			if (cmd_issue_in) begin
				count_out <= count_out + 1;
				stamp0_out <= stamp1_out;
				stamp1_out <= stamp2_out;
				stamp2_out <= cyc_r;
				last_out <= cmd_in;
			end
		end
	end
endmodule

// ### verif/test_dcs_spacing_timer.sv
`timescale 1ns/10ps
module test_dcs_spacing_timer;
	import dcs_pkg::*;
	localparam dcs_kind_type RD = DCS_CMD_READ;
	localparam dcs_kind_type WR = DCS_CMD_WRITE;
	logic clock_in = 0, rst_in = 1, avs_read = 0, avs_write = 0, cmd_valid_in = 0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic avs_waitrequest, cmd_issue_out, busy_out;
	dcs_cmd_type cmd_in = dcs_cmd_type'(4'h0), cmd_out, last;
	int err_total = 0, comparisons = 0, cyc = 0, count;
	int stamp0, stamp1, stamp2;

	dcs_spacing_timer i_dut (.clock_in(clock_in), .rst_in(rst_in), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
		.cmd_issue_out(cmd_issue_out), .cmd_out(cmd_out), .busy_out(busy_out));
	dcs_mem_model i_mem (.clock_in(clock_in), .rst_in(rst_in), .cmd_issue_in(cmd_issue_out),
		.cmd_in(cmd_out), .count_out(count), .stamp0_out(stamp0), .stamp1_out(stamp1),
		.stamp2_out(stamp2), .last_out(last));

	// ----------------------------------------------------------------
	// clock and watchdog
	// ----------------------------------------------------------------
	initial begin
		forever #4 clock_in = ~clock_in;
	end
	// run needs about 300 cycles; a hang ends here
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	function automatic dcs_cmd_type mk(input dcs_kind_type k, input logic [1:0] s);
		return '{k, s};
	endfunction
	// request held until waitrequest is sampled low at a rising edge;
	// released lines show inverted data
	task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge clock_in);
		avs_write <= wr;
		avs_read <= ~wr;
		avs_address <= ad;
		avs_writedata <= d;
		avs_byteenable <= be;
		do @(posedge clock_in); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		avs_writedata <= ~d;
	endtask
	// three commands, b due g1 after a, e due g2 after b; valid drops at e's due edge
	task automatic seq3(input logic [31:0] cfg, input dcs_cmd_type a, b, e, input int g1, g2);
		int n0;
		bus(1'b1, DCS_ADDR_CONFIG, cfg, 4'hF);
		repeat (16) @(posedge clock_in);
		n0 = count;
		@(posedge clock_in);
		cmd_valid_in <= 1'b1;
		cmd_in <= a;
		@(posedge clock_in);
		cmd_in <= b;
		repeat (g1 - 1) @(posedge clock_in);
		@(negedge clock_in);
		chk("busy", busy_out, g1 > 1);
		@(posedge clock_in);
		cmd_in <= e;
		repeat (g2) @(posedge clock_in);
		cmd_valid_in <= 1'b0;
		cmd_in <= dcs_cmd_type'(~e);
		repeat (3) @(posedge clock_in);
		@(negedge clock_in);
		chk("issued", count - n0, 3);
		chk("first gap", stamp1 - stamp0, g1);
		chk("second gap", stamp2 - stamp1, g2);
		chk("cmd", last, e);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic scen_regs();
		bus(1'b0, DCS_ADDR_CONFIG, 32'h0, 4'h0);
		chk("config reset", rd, DCS_CONFIG_RESET);
		bus(1'b1, DCS_ADDR_CONFIG, 32'hA5A5A5A5, 4'h5);
		bus(1'b1, 4'h8, 32'hFFFFFFFF, 4'hF);
		bus(1'b0, DCS_ADDR_CONFIG, 32'h0, 4'h0);
		chk("config lanes", rd, 32'h00A500A5);
		bus(1'b0, 4'h8, 32'h0, 4'h0);
		chk("unmapped", rd, 32'h0);
	endtask
	task automatic scen_reads();
		seq3(32'h0000350F, mk(RD, 2'h0), mk(RD, 2'h0), mk(RD, 2'h1), 5, 3);
	endtask
	task automatic scen_writes();
		seq3(32'h00640F00, mk(WR, 2'h0), mk(WR, 2'h0), mk(WR, 2'h1), 4, 6);
	endtask
	task automatic scen_turn();
		seq3(32'hF7000002, mk(RD, 2'h0), mk(WR, 2'h1), mk(RD, 2'h1), 7, 2);
	endtask
	task automatic scen_cross();
		seq3(32'h0000036F, mk(WR, 2'h0), mk(RD, 2'h1), mk(RD, 2'h1), 6, 3);
	endtask
	// the older same-select read still governs over the newer write
	task automatic scen_largest();
		seq3(32'h02000930, mk(RD, 2'h0), mk(WR, 2'h1), mk(RD, 2'h0), 2, 7);
	endtask
	task automatic scen_rmw();
		seq3(32'h500F0000, mk(RD, 2'h0), mk(DCS_CMD_RMW_WRITE, 2'h0), mk(RD, 2'h0), 5, 1);
	endtask
	// gap 0 acts as back to back, gap 15 is the longest field value
	task automatic scen_bounds();
		seq3(32'h00F0000F, mk(WR, 2'h3), mk(WR, 2'h3), mk(RD, 2'h3), 1, 15);
	endtask
	// status shows a held offer while a same-select read gap runs, then idle
	task automatic scen_status();
		int n0;
		bus(1'b1, DCS_ADDR_CONFIG, 32'h00000F00, 4'hF);
		repeat (16) @(posedge clock_in);
		n0 = count;
		cmd_valid_in <= 1'b1;
		cmd_in <= mk(RD, 2'h2);
		@(posedge clock_in);
		bus(1'b0, DCS_ADDR_STATUS, 32'h0, 4'h0);
		chk("status held", rd, 32'h00000002);
		repeat (16) @(posedge clock_in);
		cmd_valid_in <= 1'b0;
		bus(1'b0, DCS_ADDR_STATUS, 32'h0, 4'h0);
		chk("status idle", rd, 32'h00000000);
		chk("held issues", count - n0, 2);
	endtask

	task summarize();
		if (err_total == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clock_in);
		rst_in <= 1'b0;
		scen_regs();
		scen_reads();
		scen_writes();
		scen_turn();
		scen_cross();
		scen_largest();
		scen_rmw();
		scen_bounds();
		scen_status();
		summarize();
	end
endmodule
